// *** hw/uoc_out_ep.sv ***
`timescale 1ns/1ps
// Functional notes
// - Control high bit 7 enables double buffering; resets to zero
// - Control high bit 6 selects isochronous when one, bulk/interrupt otherwise
// - Unused control bits 5:0 and count high 7:2 read zero, ignore writes
// - Ten-bit length of the oldest held packet kept; low register shows bits 7:0
// - Count high register bits 1:0 show length bits 9:8
// - Packet-ready sets whenever a packet is held; firmware clears it
// - With two packets held, packet-ready sets again after clear, new event
`include "uoc_params.svh"

module uoc_out_ep
	import uoc_pkg::*;
#(
	parameter int NUM_EP = 4,
	parameter int EP_W = 2,
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [EP_W-1:0] rx_ep,
	input wire logic [9:0] rx_len,
	output logic rx_ready,
	output logic [NUM_EP-1:0] ep_packet_ready,
	output logic [NUM_EP-1:0] ep_iso_mode,
	output logic pkt_ready_event
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [NUM_EP-1:0] dbl;
	logic [NUM_EP-1:0] iso;
	logic [NUM_EP-1:0] opr;
	logic [NUM_EP-1:0] rise;
	uoc_held_type held [NUM_EP];
	uoc_len_type len_a [NUM_EP];
	uoc_len_type len_b [NUM_EP];
	logic [EP_W-1:0] sel;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pwrite;
	wire [ADDR_W-1:0] a_ctrl = ADDR_W'({`UOC_IDX_CTRL_HI, 2'b00});
	wire [ADDR_W-1:0] a_lo = ADDR_W'({`UOC_IDX_LEN_LO, 2'b00});
	wire [ADDR_W-1:0] a_hi = ADDR_W'({`UOC_IDX_LEN_HI, 2'b00});
	wire [ADDR_W-1:0] a_stat = ADDR_W'({`UOC_IDX_STATUS, 2'b00});
	wire [ADDR_W-1:0] a_sel = ADDR_W'({`UOC_IDX_EP_SEL, 2'b00});
	wire hit_ctrl = paddr == a_ctrl;
	wire hit_lo = paddr == a_lo;
	wire hit_hi = paddr == a_hi;
	wire hit_stat = paddr == a_stat;
	wire hit_sel = paddr == a_sel;
	wire mapped = hit_ctrl | hit_lo | hit_hi | hit_stat | hit_sel;
	wire wr_ctrl = wr_en & hit_ctrl;
	wire wr_sel = wr_en & hit_sel;
	// Only writing a zero clears; hardware alone sets the flag
	wire clr_req = wr_en & hit_stat & ~pwdata[`UOC_OPR_BIT];

	// Zero-wait slave: read data is latched in the setup cycle
	assign pready = psel & penable;

	// ------------------------------------------------------------
	// Selected endpoint view
	// ------------------------------------------------------------
	wire uoc_len_type cur_len = len_a[sel];
	// Full means the buffering limit is reached or passed
	wire [1:0] cur_limit = dbl[sel] ? 2'd2 : 2'd1;
	wire cur_full = held[sel] >= cur_limit;
	wire [31:0] rd_ctrl = {24'h00_0000, dbl[sel], iso[sel], 6'b00_0000};
	wire [31:0] rd_lo = {24'h00_0000, cur_len[7:0]};
	wire [31:0] rd_hi = {24'h00_0000, 6'b00_0000, cur_len[9:8]};
	wire [31:0] rd_stat = {30'h0000_0000, cur_full, opr[sel]};
	wire [31:0] rd_sel = {{(32-EP_W){1'b0}}, sel};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_lo ? rd_lo :
		hit_hi ? rd_hi :
		hit_stat ? rd_stat :
		hit_sel ? rd_sel : 32'h0000_0000;

	// Latch the answer while the setup cycle is on the bus
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= ~mapped;
		end
	end

	// Endpoint index register
	always_ff @(posedge clk) begin
		if (rst) begin
			sel <= '0;
		end else if (wr_sel) begin
			sel <= pwdata[EP_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Receive side: a full endpoint refuses, nothing is dropped
	// ------------------------------------------------------------
	// Less-than, not inequality: turning double buffering off while two
	// packets wait must not let a third one overwrite the queue
	wire [1:0] rx_limit = dbl[rx_ep] ? 2'd2 : 2'd1;
	assign rx_ready = held[rx_ep] < rx_limit;

	// ------------------------------------------------------------
	// Per-endpoint FIFO bookkeeping
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++) begin : g_ep
			wire mine = sel == EP_W'(g);
			wire push = rx_valid & rx_ready & (rx_ep == EP_W'(g));
			wire pop = clr_req & mine & opr[g];
			wire uoc_held_type after_pop = held[g] - {1'b0, pop};
			wire uoc_held_type next_held = after_pop + {1'b0, push};

			// Configuration bits; unused bits are never stored
			always_ff @(posedge clk) begin
				if (rst) begin
					dbl[g] <= `UOC_CTRL_RESET;
					iso[g] <= `UOC_CTRL_RESET;
				end else if (wr_ctrl & mine) begin
					dbl[g] <= pwdata[`UOC_DBL_BIT];
					iso[g] <= pwdata[`UOC_ISO_BIT];
				end
			end

			// Lengths shift forward when the head packet is unloaded
			always_ff @(posedge clk) begin
				if (rst) begin
					held[g] <= `UOC_HELD_RESET;
					len_a[g] <= `UOC_LEN_RESET;
					len_b[g] <= `UOC_LEN_RESET;
				end else begin
					held[g] <= next_held;
					if (pop) begin
						len_a[g] <= len_b[g];
					end
					if (push & after_pop == 2'd0) begin
						len_a[g] <= rx_len;
					end else if (push) begin
						len_b[g] <= rx_len;
					end
				end
			end

			// Flag re-arms one cycle after a clear if a packet remains
			assign rise[g] = ~opr[g] & (held[g] != 2'd0);
			always_ff @(posedge clk) begin
				if (rst) begin
					opr[g] <= 1'b0;
				end else if (rise[g]) begin
					opr[g] <= 1'b1;
				end else if (pop) begin
					opr[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Event pulse feeds the controller's interrupt path
	always_ff @(posedge clk) begin
		if (rst) begin
			pkt_ready_event <= 1'b0;
		end else begin
			pkt_ready_event <= |rise;
		end
	end

	// ------------------------------------------------------------
	// Flag and mode outputs, straight from their flip-flops
	// ------------------------------------------------------------
	assign ep_packet_ready = opr;
	assign ep_iso_mode = iso;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Firmware reads length only under the flag; length stays put then
	a_len_steady: assert property (@(posedge clk) disable iff (rst)
		(opr[0] && $past(opr[0]) && !$past(clr_req)) |-> $stable(len_a[0]))
		else $error("head length moved while flag held");

	a_ctrl_unused: assert property (@(posedge clk) disable iff (rst)
		(setup && !pwrite && hit_ctrl) |=> prdata[5:0] == 6'b00_0000)
		else $error("control high unused bits not zero");

	a_hi_unused: assert property (@(posedge clk) disable iff (rst)
		(setup && !pwrite && hit_hi) |=> prdata[31:2] == 30'h0000_0000)
		else $error("count high unused bits not zero");

	a_dbl_write: assert property (@(posedge clk) disable iff (rst)
		wr_ctrl |=> dbl[$past(sel)] == $past(pwdata[7]))
		else $error("double buffer bit not written");

	a_iso_write: assert property (@(posedge clk) disable iff (rst)
		wr_ctrl |=> ep_iso_mode[$past(sel)] == $past(pwdata[6]))
		else $error("iso bit not written");

	a_len_low: assert property (@(posedge clk) disable iff (rst)
		(setup && !pwrite && hit_lo) |=> prdata[7:0] == $past(cur_len[7:0]))
		else $error("count low mismatch");

	a_len_high: assert property (@(posedge clk) disable iff (rst)
		(setup && !pwrite && hit_hi) |=> prdata[1:0] == $past(cur_len[9:8]))
		else $error("count high mismatch");

	a_flag_set: assert property (@(posedge clk) disable iff (rst)
		(held[0] != 2'd0 && !opr[0]) |=> opr[0])
		else $error("packet ready not set");

	a_flag_rearm: assert property (@(posedge clk) disable iff (rst)
		(g_ep[0].pop && held[0] == 2'd2) |=> !opr[0] ##1 (opr[0] && pkt_ready_event))
		else $error("second packet not re-armed");

	a_ep_separate: assert property (@(posedge clk) disable iff (rst)
		(wr_ctrl && sel != '0) |=> dbl[0] == $past(dbl[0]) && iso[0] == $past(iso[0]))
		else $error("other endpoint config changed");

	// Acceptance follows the buffering limit of the target endpoint
	a_rx_refuse: assert property (@(posedge clk) disable iff (rst)
		(rx_ep == EP_W'(1) && held[1] != 2'd0 && !dbl[1]) |-> !rx_ready)
		else $error("single buffer took a second packet");

	a_dbl_room: assert property (@(posedge clk) disable iff (rst)
		(rx_ep == '0 && held[0] == 2'd1 && dbl[0]) |-> rx_ready)
		else $error("double buffer refused a second packet");

	a_full_status: assert property (@(posedge clk) disable iff (rst)
		(setup && !pwrite && hit_stat && sel == '0 && held[0] == 2'd2) |=> prdata[1])
		else $error("full not reported with two held");

	// Lengths land where the unload order expects them
	a_len_capture: assert property (@(posedge clk) disable iff (rst)
		(g_ep[0].push && held[0] == 2'd0) |=> len_a[0] == $past(rx_len))
		else $error("first length not captured");

	a_len_queue: assert property (@(posedge clk) disable iff (rst)
		(g_ep[0].push && held[0] == 2'd1 && !g_ep[0].pop) |=> len_b[0] == $past(rx_len))
		else $error("second length not queued");

	a_len_advance: assert property (@(posedge clk) disable iff (rst)
		(g_ep[0].pop && held[0] == 2'd2) |=> len_a[0] == $past(len_b[0]))
		else $error("queued length not moved forward");

	a_count_ro: assert property (@(posedge clk) disable iff (rst)
		(wr_en && (hit_lo || hit_hi) && !rx_valid) |=>
		$stable(len_a[0]) && $stable(len_b[0]))
		else $error("count register took a write");

	// Flag, event and unload order
	a_flag_clear: assert property (@(posedge clk) disable iff (rst)
		g_ep[0].pop |=> !opr[0])
		else $error("packet ready not cleared");

	a_flag_held: assert property (@(posedge clk) disable iff (rst)
		opr[0] |-> held[0] != 2'd0)
		else $error("packet ready with empty buffer");

	a_event_rise: assert property (@(posedge clk) disable iff (rst)
		$rose(opr[0]) |-> pkt_ready_event)
		else $error("flag rose without an event");

	// Index writes and per-endpoint separation
	a_sel_write: assert property (@(posedge clk) disable iff (rst)
		wr_sel |=> sel == $past(pwdata[EP_W-1:0]))
		else $error("endpoint index not written");

	a_len_separate: assert property (@(posedge clk) disable iff (rst)
		(g_ep[1].push && !g_ep[0].push && !g_ep[0].pop) |=>
		$stable(len_a[0]) && $stable(len_b[0]))
		else $error("other endpoint length changed");

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	c_double_held: cover property (@(posedge clk) disable iff (rst)
		held[0] == 2'd2);
	c_rearm: cover property (@(posedge clk) disable iff (rst)
		g_ep[0].pop ##1 !opr[0] ##1 opr[0]);
	c_refused: cover property (@(posedge clk) disable iff (rst)
		rx_valid && !rx_ready);
	c_bad_addr: cover property (@(posedge clk) disable iff (rst)
		pready && pslverr);
	c_last_unload: cover property (@(posedge clk) disable iff (rst)
		g_ep[0].pop && held[0] == 2'd1);

endmodule // uoc_out_ep

// *** hw/uoc_params.svh ***
`ifndef UOC_PARAMS_SVH
`define UOC_PARAMS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define UOC_IDX_CTRL_HI 8'h15
`define UOC_IDX_LEN_LO 8'h16
`define UOC_IDX_LEN_HI 8'h17
`define UOC_IDX_STATUS 8'h20
`define UOC_IDX_EP_SEL 8'h21

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define UOC_DBL_BIT 7
`define UOC_ISO_BIT 6
`define UOC_OPR_BIT 0
`define UOC_FULL_BIT 1
`define UOC_CTRL_RESET 1'b0
`define UOC_LEN_RESET 10'h000
`define UOC_HELD_RESET 2'h0

`endif

// *** hw/uoc_pkg.sv ***
package uoc_pkg;
	// Received packet length, ten bits
	typedef logic [9:0] uoc_len_type;
	// Packets held by one endpoint FIFO, zero to two
	typedef logic [1:0] uoc_held_type;
endpackage

// *** test/uoc_host_model.sv ***
`timescale 1ns/1ps
// ------------------------------
// Host side: OUT data packets
// ------------------------------
module uoc_host_model (
	input wire logic clk,
	input wire logic rx_ready,
	output logic rx_valid,
	output logic [1:0] rx_ep,
	output logic [9:0] rx_len
);
	initial begin
		rx_valid = 1'b0;
		rx_ep = 2'h0;
		rx_len = 10'h000;
	end
	// Offer one packet for up to limit edges; a refusal just stalls the host.
	// Ready is taken at the same rising edge at which the block samples it.
	task automatic send(input logic [1:0] ep, input logic [9:0] len, input int limit,
		output logic taken);
		taken = 1'b0;
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_ep <= ep;
		rx_len <= len;
		for (int n = 0; n < limit && !taken; n++) begin
			@(posedge clk);
			taken = rx_ready;
		end
		// Stale fields scrambled so nothing leans on them
		rx_valid <= 1'b0;
		rx_ep <= ~ep;
		rx_len <= ~len;
	endtask
endmodule // uoc_host_model

// *** test/usb_out_endpoint_cfg_count_bench.sv ***
`timescale 1ns/1ps
`include "uoc_params.svh"
module usb_out_endpoint_cfg_count_bench;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic rx_valid, rx_ready, pkt_ready_event, err, taken;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] rx_ep;
	logic [9:0] rx_len;
	logic [3:0] ep_packet_ready, ep_iso_mode;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_event = 0;
	localparam logic [7:0] A_CTL = 8'(`UOC_IDX_CTRL_HI * 4);
	localparam logic [7:0] A_LO = 8'(`UOC_IDX_LEN_LO * 4);
	localparam logic [7:0] A_HI = 8'(`UOC_IDX_LEN_HI * 4);
	localparam logic [7:0] A_ST = 8'(`UOC_IDX_STATUS * 4);
	localparam logic [7:0] A_SEL = 8'(`UOC_IDX_EP_SEL * 4);

	uoc_out_ep u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_ep(rx_ep),
		.rx_len(rx_len), .rx_ready(rx_ready), .ep_packet_ready(ep_packet_ready),
		.ep_iso_mode(ep_iso_mode), .pkt_ready_event(pkt_ready_event));
	uoc_host_model u_host (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_ep(rx_ep), .rx_len(rx_len));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Interrupt sources counted, replay must add one
	always @(posedge clk) begin
		if (!rst && pkt_ready_event === 1'b1) n_event++;
	end

	// ------------------------------
	// Access and compare tasks
	// ------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// One APB transfer; entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] %0t no ready", $time);
			test_done();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	// Packet the host must get in; a stalled host ends the run
	task automatic push(input logic [1:0] ep, input logic [9:0] len);
		logic t;
		u_host.send(ep, len, 50, t);
		if (t !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] %0t packet not taken", $time);
			test_done();
		end
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(A_CTL, 32'h0000_0000);
		rdc(A_LO, 32'h0000_0000);
		rdc(A_HI, 32'h0000_0000);
		apb(1'b1, A_CTL, 32'hFFFF_FFFF);
		apb(1'b1, A_LO, 32'hFFFF_FFFF);
		apb(1'b1, A_HI, 32'hFFFF_FFFF);
		rdc(A_CTL, 32'h0000_00C0);
		rdc(A_LO, 32'h0000_0000);
		rdc(A_HI, 32'h0000_0000);
		chk(32'(ep_iso_mode), 32'h0000_0001);
		apb(1'b1, A_SEL, 32'h0000_0001);
		rdc(A_CTL, 32'h0000_0000);
		// Two packets on the double-buffered endpoint, one on the single
		push(2'h0, 10'h3A5);
		push(2'h0, 10'h0C3);
		push(2'h1, 10'h001);
		// Flag rises one edge after the take; firmware waits for it
		repeat (2) @(posedge clk);
		chk(32'(ep_packet_ready), 32'h0000_0003);
		rdc(A_ST, 32'h0000_0003);
		rdc(A_LO, 32'h0000_0001);
		// Single-buffered endpoint already holds one: the host must stall
		u_host.send(2'h1, 10'h2AA, 4, taken);
		chk(32'(taken), 32'h0000_0000);
		rdc(A_LO, 32'h0000_0001);
		apb(1'b1, A_SEL, 32'h0000_0000);
		rdc(A_ST, 32'h0000_0003);
		rdc(A_LO, 32'h0000_00A5);
		rdc(A_HI, 32'h0000_0003);
		apb(1'b1, A_ST, 32'h0000_0000);
		rdc(A_ST, 32'h0000_0001);
		rdc(A_LO, 32'h0000_00C3);
		rdc(A_HI, 32'h0000_0000);
		chk(32'(n_event), 32'h0000_0003);
		apb(1'b1, A_ST, 32'h0000_0000);
		rdc(A_ST, 32'h0000_0000);
		chk(32'(ep_packet_ready), 32'h0000_0002);
		apb(1'b0, 8'hF0, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
		test_done();
	end
endmodule // usb_out_endpoint_cfg_count_bench
